// [rtl/fieldbus_io_image_mapper_params.svh]
// Constants of the fieldbus process-image mapper.
// Assumes one 25 MHz clock and the plain register port of the mapper.
// Functional notes
// - Slave answers only when addressed
// - Input bit number is eight times byte plus bit
// - Input bytes 0 to 2 feed inputs 0-23
// - Output bit position is output number modulo eight
// - Outputs 0-23 fill output bytes 0 to 2
// - Status byte 3 exists in output direction only, and only at the default 24 points
// - Status bits 0-4 mirror the five lamps
// - Status bit 5 flags active data exchange
// - Self start after power-on or controller reset
// - Both sides supervise the cyclic traffic
// - Mapped points extendable from 24 to 128
`ifndef FIELDBUS_IO_IMAGE_MAPPER_PARAMS_SVH
`define FIELDBUS_IO_IMAGE_MAPPER_PARAMS_SVH

`define CLOCK_MHZ 25
`define IMAGE_BITS 128
`define DEFAULT_POINTS 8'h18
`define MAX_POINTS 8'h80
`define STATUS_BYTE_INDEX 3

`define STATUS_OUTPUT_FAULT_BIT 0
`define STATUS_INPUT_FAULT_BIT 1
`define STATUS_FAULT_BIT 2
`define STATUS_DIAGNOSTIC_BIT 3
`define STATUS_RUN_BIT 4
`define STATUS_EXCHANGE_BIT 5

`define CONFIG_LOAD_TIME_US 100
`define CONFIG_LOAD_CYCLES (`CONFIG_LOAD_TIME_US * `CLOCK_MHZ)
`define WATCHDOG_TIME_US 10000
`define WATCHDOG_CYCLES_DEFAULT (`WATCHDOG_TIME_US * `CLOCK_MHZ)

`define REG_CONTROL 4'h0
`define REG_STATE 4'h4
`define REG_IRQ_STATUS 4'h8
`define REG_IRQ_MASK 4'hC

`define CONTROL_RESET 32'h00000018
`define IRQ_MASK_RESET 3'h0
`define IRQ_CYCLE_BIT 0
`define IRQ_ERROR_BIT 1
`define IRQ_TIMEOUT_BIT 2

`endif

// [rtl/fieldbus_io_image_mapper_pkg.sv]
// Types of the fieldbus process-image mapper.
// Assumes the params header for all numeric constants.
package fieldbus_io_image_mapper_pkg;

	typedef enum logic [1:0] {
		st_loading,
		st_waiting,
		st_exchanging,
		st_timed_out
	} mapper_state_t;

endpackage : fieldbus_io_image_mapper_pkg

// [rtl/fieldbus_io_image_mapper.sv]
// Process-image mapper between the safety controller's virtual points and the fieldbus cyclic data.
// Assumes the protocol engine runs on the same clock; controller signals arrive as pins.
//
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`include "fieldbus_io_image_mapper_params.svh"

module fieldbus_io_image_mapper
	import fieldbus_io_image_mapper_pkg::*;
#(
	parameter int unsigned WATCHDOG_CYCLES = `WATCHDOG_CYCLES_DEFAULT
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic ctrl_reset_n,
	input wire logic [`IMAGE_BITS-1:0] virtual_out,
	input wire logic output_fault_lamp,
	input wire logic input_fault_lamp,
	input wire logic fault_lamp,
	input wire logic diagnostic_lamp,
	input wire logic run_lamp,
	output logic [`IMAGE_BITS-1:0] virtual_in,
	input wire logic bus_rx_valid,
	input wire logic bus_rx_error,
	input wire logic [`IMAGE_BITS-1:0] bus_rx_data,
	input wire logic bus_tx_request,
	output logic bus_tx_valid,
	output logic [`IMAGE_BITS-1:0] bus_tx_data,
	output logic [7:0] bus_tx_status,
	output logic exchange_active,
	input wire logic [3:0] address,
	input wire logic [31:0] write_data,
	input wire logic write_strobe,
	input wire logic read_strobe,
	output logic [31:0] read_data,
	output logic irq
);

	localparam int unsigned LOAD_CYCLES = (`CONFIG_LOAD_CYCLES < 1) ? 1 : `CONFIG_LOAD_CYCLES;
	localparam int unsigned WD_CYCLES = (WATCHDOG_CYCLES < 1) ? 1 : WATCHDOG_CYCLES;

	// Synchronisers for controller pins: two stages for image and lamps, three for the reset pin
	logic [`IMAGE_BITS-1:0] vout_meta_reg;
	logic [`IMAGE_BITS-1:0] vout_sync_reg;
	logic [4:0] lamp_meta_reg;
	logic [4:0] lamp_sync_reg;
	logic [1:0] ctrl_rst_meta_reg;
	logic ctrl_rst_sync_reg;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			vout_meta_reg <= '0;
			vout_sync_reg <= '0;
		end else begin
			vout_meta_reg <= virtual_out;
			vout_sync_reg <= vout_meta_reg;
		end
	end

	// Lamp levels, ordered as the status byte
	wire [4:0] lamp_pins = {run_lamp, diagnostic_lamp, fault_lamp, input_fault_lamp, output_fault_lamp};

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			lamp_meta_reg <= 5'h00;
			lamp_sync_reg <= 5'h00;
		end else begin
			lamp_meta_reg <= lamp_pins;
			lamp_sync_reg <= lamp_meta_reg;
		end
	end

	// Controller reset pin
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_rst_meta_reg <= 2'h0;
			ctrl_rst_sync_reg <= 1'b0;
		end else begin
			ctrl_rst_meta_reg <= {ctrl_rst_meta_reg[0], ctrl_reset_n};
			ctrl_rst_sync_reg <= ctrl_rst_meta_reg[1];
		end
	end

	// Controller reset edge: falling synced level
	logic ctrl_rst_prev_reg;
	wire ctrl_reset_seen = ctrl_rst_prev_reg & ~ctrl_rst_sync_reg;
	wire ctrl_in_reset = ~ctrl_rst_sync_reg;

	// Register decode
	wire sel_control = (address == `REG_CONTROL);
	wire sel_state = (address == `REG_STATE);
	wire sel_irq_status = (address == `REG_IRQ_STATUS);
	wire sel_irq_mask = (address == `REG_IRQ_MASK);
	wire wr_control = write_strobe & sel_control;
	wire wr_irq_status = write_strobe & sel_irq_status;
	wire wr_irq_mask = write_strobe & sel_irq_mask;

	// Number of mapped points, clamped to the legal range
	logic [7:0] points_reg;
	logic [7:0] points_next;
	wire [7:0] points_req = write_data[7:0];
	wire points_low = (points_req < `DEFAULT_POINTS);
	wire points_high = (points_req > `MAX_POINTS);
	assign points_next = points_low ? `DEFAULT_POINTS : points_high ? `MAX_POINTS : points_req;

	// Mask of configured point numbers, bit n is byte n/8 bit n%8
	logic [`IMAGE_BITS-1:0] point_mask;
	genvar gi;
	generate
		for (gi = 0; gi < `IMAGE_BITS; gi = gi + 1) begin : g_mask
			assign point_mask[gi] = (8'(gi) < points_reg);
		end
	endgenerate

	// Sequencer
	mapper_state_t state_reg;
	mapper_state_t state_next;
	logic [$clog2(LOAD_CYCLES+1)-1:0] load_cnt_reg;
	logic [$clog2(WD_CYCLES+1)-1:0] wd_cnt_reg;
	wire load_done = (load_cnt_reg == ($clog2(LOAD_CYCLES+1))'(LOAD_CYCLES - 1));
	wire wd_expired = (wd_cnt_reg == ($clog2(WD_CYCLES+1))'(WD_CYCLES - 1));
	wire rx_good = bus_rx_valid & ~bus_rx_error;
	wire rx_bad = bus_rx_valid & bus_rx_error;
	wire running = (state_reg == st_waiting) | (state_reg == st_exchanging) | (state_reg == st_timed_out);

	// Transition and counter restart terms
	wire leave_loading = load_done & ~ctrl_in_reset;
	wire lose_exchange = rx_bad | wd_expired;
	wire restart_load = ctrl_reset_seen | ctrl_in_reset;
	wire load_clear = (state_reg != st_loading);
	wire wd_clear = (state_reg != st_exchanging) | rx_good;

	// State code as software sees it
	logic [1:0] state_code;
	always_comb begin
		state_code = 2'h0;
		unique case (state_reg)
			st_loading: state_code = 2'h0;
			st_waiting: state_code = 2'h1;
			st_exchanging: state_code = 2'h2;
			st_timed_out: state_code = 2'h3;
		endcase
	end

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			st_loading: begin
				if (leave_loading) begin
					state_next = st_waiting;
				end
			end
			st_waiting: begin
				if (rx_good) begin
					state_next = st_exchanging;
				end
			end
			st_exchanging: begin
				if (lose_exchange) begin
					state_next = st_timed_out;
				end
			end
			st_timed_out: begin
				if (rx_good) begin
					state_next = st_exchanging;
				end
			end
		endcase
		if (restart_load) begin
			state_next = st_loading;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= st_loading;
			ctrl_rst_prev_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			ctrl_rst_prev_reg <= ctrl_rst_sync_reg;
		end
	end

	// Point count, written through the control register
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			points_reg <= `DEFAULT_POINTS;
		end else if (wr_control) begin
			points_reg <= points_next;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			load_cnt_reg <= '0;
		end else if (load_clear) begin
			load_cnt_reg <= '0;
		end else if (!load_done) begin
			load_cnt_reg <= load_cnt_reg + 1'b1;
		end
	end

	// Watchdog restarts on each good cycle
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			wd_cnt_reg <= '0;
		end else if (wd_clear) begin
			wd_cnt_reg <= '0;
		end else if (!wd_expired) begin
			wd_cnt_reg <= wd_cnt_reg + 1'b1;
		end
	end

	// Input image applied whole, cleared when exchange is lost
	logic [`IMAGE_BITS-1:0] virtual_in_next;
	wire [`IMAGE_BITS-1:0] rx_image = bus_rx_data & point_mask;
	wire take_rx = running & rx_good;
	wire keep_rx = (state_next == st_exchanging);

	assign virtual_in_next = take_rx ? rx_image : keep_rx ? virtual_in : '0;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			virtual_in <= '0;
		end else begin
			virtual_in <= virtual_in_next;
		end
	end

	// Output image and status byte, answered only on request
	wire exchange_now = (state_reg == st_exchanging);
	logic [7:0] status_byte;

	// Status byte, lamps then exchange flag
	always_comb begin
		status_byte = 8'h00;
		status_byte[`STATUS_OUTPUT_FAULT_BIT] = lamp_sync_reg[`STATUS_OUTPUT_FAULT_BIT];
		status_byte[`STATUS_INPUT_FAULT_BIT] = lamp_sync_reg[`STATUS_INPUT_FAULT_BIT];
		status_byte[`STATUS_FAULT_BIT] = lamp_sync_reg[`STATUS_FAULT_BIT];
		status_byte[`STATUS_DIAGNOSTIC_BIT] = lamp_sync_reg[`STATUS_DIAGNOSTIC_BIT];
		status_byte[`STATUS_RUN_BIT] = lamp_sync_reg[`STATUS_RUN_BIT];
		status_byte[`STATUS_EXCHANGE_BIT] = exchange_now;
	end

	wire default_layout = (points_reg == `DEFAULT_POINTS);
	wire [`IMAGE_BITS-1:0] vout_image = vout_sync_reg & point_mask;
	logic [`IMAGE_BITS-1:0] tx_image;
	always_comb begin
		tx_image = vout_image;
		if (default_layout) begin
			tx_image[`STATUS_BYTE_INDEX*8 +: 8] = status_byte;
		end
	end

	wire answer_now = bus_tx_request & running;

	// Answer pulse and exchange flag
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			bus_tx_valid <= 1'b0;
			exchange_active <= 1'b0;
		end else begin
			bus_tx_valid <= answer_now;
			exchange_active <= (state_next == st_exchanging);
		end
	end

	// Snapshot taken only when the master fetches
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			bus_tx_data <= '0;
			bus_tx_status <= 8'h00;
		end else if (answer_now) begin
			bus_tx_data <= tx_image;
			bus_tx_status <= status_byte;
		end
	end

	// Interrupt sources: good cycle, disturbed cycle, timeout
	wire irq_cycle_event = rx_good & running;
	wire irq_error_event = rx_bad & running;
	wire irq_timeout_event = exchange_now & wd_expired;
	logic [2:0] irq_events;
	logic [2:0] irq_status_reg;
	logic [2:0] irq_mask_reg;

	always_comb begin
		irq_events = 3'h0;
		irq_events[`IRQ_CYCLE_BIT] = irq_cycle_event;
		irq_events[`IRQ_ERROR_BIT] = irq_error_event;
		irq_events[`IRQ_TIMEOUT_BIT] = irq_timeout_event;
	end

	// Write one clears; an event in the same cycle wins
	wire [2:0] irq_clear = wr_irq_status ? write_data[2:0] : 3'h0;
	wire [2:0] irq_status_next = (irq_status_reg & ~irq_clear) | irq_events;
	wire [2:0] irq_mask_next = wr_irq_mask ? write_data[2:0] : irq_mask_reg;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			irq_status_reg <= 3'h0;
		end else begin
			irq_status_reg <= irq_status_next;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			irq_mask_reg <= `IRQ_MASK_RESET;
		end else begin
			irq_mask_reg <= irq_mask_next;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status_next & irq_mask_next);
		end
	end

	// Read mux, unmapped addresses read zero
	wire [31:0] read_control = {24'h000000, points_reg};
	wire [31:0] read_state = {24'h000000, exchange_now, 5'h00, state_code};
	wire [31:0] read_irq_status = {29'h00000000, irq_status_reg};
	wire [31:0] read_irq_mask = {29'h00000000, irq_mask_reg};

	wire [31:0] read_mux = sel_control ? read_control :
		sel_state ? read_state :
		sel_irq_status ? read_irq_status :
		sel_irq_mask ? read_irq_mask : 32'h00000000;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			read_data <= 32'h00000000;
		end else if (read_strobe) begin
			read_data <= read_mux;
		end else begin
			read_data <= 32'h00000000;
		end
	end

endmodule : fieldbus_io_image_mapper

// [verif/fieldbus_io_image_mapper_chk.sv]
// Port checker of the process-image mapper.
// Assumes binding to the mapper top module.
`timescale 1ns/1ps
`include "fieldbus_io_image_mapper_params.svh"
module fieldbus_io_image_mapper_chk (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic write_strobe,
	input wire logic bus_rx_valid,
	input wire logic bus_rx_error,
	input wire logic [`IMAGE_BITS-1:0] bus_rx_data,
	input wire logic bus_tx_request,
	input wire logic bus_tx_valid,
	input wire logic [`IMAGE_BITS-1:0] bus_tx_data,
	input wire logic [7:0] bus_tx_status,
	input wire logic [`IMAGE_BITS-1:0] virtual_in,
	input wire logic exchange_active
);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	tx_answer_a: assert property (bus_tx_valid |-> $past(bus_tx_request))
		else $error("answer unasked");
	tx_pad_a: assert property (bus_tx_valid |-> bus_tx_status[7:6] == 2'h0)
		else $error("pad bits set");
	tx_exchange_a: assert property (bus_tx_valid |-> bus_tx_status[5] == $past(exchange_active))
		else $error("exchange bit wrong");
	tx_hold_a: assert property (!bus_tx_valid |-> $stable(bus_tx_data))
		else $error("image moved unasked");
	rx_map_a: assert property (bus_rx_valid && !bus_rx_error && exchange_active |=> virtual_in[23:0] == $past(bus_rx_data[23:0]))
		else $error("input map wrong");
	rx_error_a: assert property (bus_rx_valid && bus_rx_error && exchange_active |=> !exchange_active && virtual_in == 128'h0)
		else $error("bad frame kept");
	rx_atomic_a: assert property ($changed(virtual_in) |-> $past(bus_rx_valid) || $past(write_strobe) || virtual_in == 128'h0)
		else $error("inputs moved alone");
	exch_start_a: assert property ($rose(exchange_active) |-> $past(bus_rx_valid && !bus_rx_error))
		else $error("exchange without frame");
	cover property (bus_tx_valid && bus_tx_status[5]);
	cover property (bus_rx_valid && bus_rx_error && exchange_active);
	cover property ($rose(exchange_active));
endmodule : fieldbus_io_image_mapper_chk
bind fieldbus_io_image_mapper fieldbus_io_image_mapper_chk i_chk (.clock, .reset_n, .write_strobe, .bus_rx_valid,
	.bus_rx_error, .bus_rx_data, .bus_tx_request, .bus_tx_valid, .bus_tx_data, .bus_tx_status, .virtual_in, .exchange_active);

// [verif/fieldbus_master_model.sv]
// Cyclic fieldbus master: frame, then fetch, every nine cycles.
// Assumes one clock shared with the mapper.
`timescale 1ns/1ps
module fieldbus_master_model (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic run,
	input wire logic corrupt,
	input wire logic [127:0] image,
	input wire logic bus_tx_valid,
	input wire logic [127:0] bus_tx_data,
	input wire logic [7:0] bus_tx_status,
	output logic bus_rx_valid,
	output logic bus_rx_error,
	output logic [127:0] bus_rx_data,
	output logic bus_tx_request,
	output logic [127:0] got_data,
	output logic [7:0] got_status
);
	logic [3:0] phase;
	wire frame = run && phase == 4'h0;
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			phase <= 4'h0;
			bus_rx_valid <= 1'h0;
			bus_rx_error <= 1'h0;
			bus_rx_data <= 128'h0;
			bus_tx_request <= 1'h0;
			got_data <= 128'h0;
			got_status <= 8'h0;
		end else begin
			phase <= phase == 4'h8 ? 4'h0 : phase + 4'h1;
			bus_rx_valid <= frame;
			bus_rx_error <= frame && corrupt;
			bus_rx_data <= frame ? image : ~image;
			bus_tx_request <= run && phase == 4'h1;
			if (bus_tx_valid) begin
				got_data <= bus_tx_data;
				got_status <= bus_tx_status;
			end
		end
	end
endmodule : fieldbus_master_model

// [verif/tb_top.sv]
// Self-checking bench of the process-image mapper.
// Assumes the master model and the bound checker.
`timescale 1ns/1ps
module tb_top;
	logic clock = 1'h0;
	logic reset_n = 1'h0;
	logic ctrl_reset_n = 1'h1;
	logic [127:0] virtual_out = ~128'h0;
	logic [4:0] lamps = 5'h16;
	logic [127:0] image = {4{32'hA5C30F96}};
	logic run = 1'h0;
	logic corrupt = 1'h0;
	logic [3:0] address = 4'h0;
	logic [31:0] write_data = 32'h0;
	logic write_strobe = 1'h0;
	logic read_strobe = 1'h0;
	logic [127:0] virtual_in, bus_rx_data, bus_tx_data, got_data;
	logic [31:0] read_data;
	logic [7:0] bus_tx_status, got_status;
	logic bus_rx_valid, bus_rx_error, bus_tx_request, bus_tx_valid, exchange_active, irq;
	int bad_count = 0;
	int comparisons = 0;
	always #20 clock = ~clock;
	fieldbus_io_image_mapper #(.WATCHDOG_CYCLES(50)) i_dut (.clock, .reset_n, .ctrl_reset_n, .virtual_out,
		.output_fault_lamp(lamps[0]), .input_fault_lamp(lamps[1]), .fault_lamp(lamps[2]),
		.diagnostic_lamp(lamps[3]), .run_lamp(lamps[4]), .virtual_in, .bus_rx_valid, .bus_rx_error, .bus_rx_data,
		.bus_tx_request, .bus_tx_valid, .bus_tx_data, .bus_tx_status, .exchange_active, .address, .write_data,
		.write_strobe, .read_strobe, .read_data, .irq);
	fieldbus_master_model i_master (.clock, .reset_n, .run, .corrupt, .image, .bus_tx_valid, .bus_tx_data,
		.bus_tx_status, .bus_rx_valid, .bus_rx_error, .bus_rx_data, .bus_tx_request, .got_data, .got_status);
	task automatic check(input logic [127:0] seen, input logic [127:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic pause(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : pause
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		address <= a;
		write_data <= d;
		write_strobe <= 1'h1;
		@(posedge clock);
		write_strobe <= 1'h0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge clock);
		address <= a;
		read_strobe <= 1'h1;
		@(posedge clock);
		read_strobe <= 1'h0;
		#1 check(128'(read_data), 128'(e));
	endtask : rd
	task automatic wait_exch();
		@(posedge clock) run <= 1'h1;
		repeat (3000) if (exchange_active !== 1'h1) @(posedge clock);
		#1 check(128'(exchange_active), 128'h1);
	endtask : wait_exch
	task automatic t_boot();
		@(posedge clock) run <= 1'h1;
		rd(4'h0, 32'h18);
		rd(4'hC, 32'h0);
		rd(4'h4, 32'h0);
		wr(4'h2, 32'hFF);
		rd(4'h2, 32'h0);
		pause(40);
		check(virtual_in, 128'h0);
		check(got_data, 128'h0);
		wait_exch();
		pause(30);
		check(virtual_in, image & 128'hFFFFFF);
		check(got_data, {96'h0, 3'h1, lamps, virtual_out[23:0]});
		check(128'(got_status), {120'h0, 3'h1, lamps});
		rd(4'h4, 32'h82);
		rd(4'h8, 32'h1);
		check(128'(irq), 128'h0);
	endtask : t_boot
	task automatic t_extend();
		wr(4'h0, 32'hC8);
		rd(4'h0, 32'h80);
		pause(30);
		check(virtual_in, image);
		check(got_data, virtual_out);
		wr(4'h0, 32'h5);
		rd(4'h0, 32'h18);
	endtask : t_extend
	task automatic t_timeout();
		@(posedge clock) run <= 1'h0;
		pause(80);
		check(128'(exchange_active), 128'h0);
		check(virtual_in, 128'h0);
		rd(4'h4, 32'h3);
		rd(4'h8, 32'h5);
		wr(4'hC, 32'h4);
		pause(2);
		check(128'(irq), 128'h1);
		wr(4'h8, 32'h7);
		pause(2);
		check(128'(irq), 128'h0);
	endtask : t_timeout
	task automatic t_error();
		wait_exch();
		@(posedge clock) corrupt <= 1'h1;
		pause(20);
		check(128'(got_status[5]), 128'h0);
		check(virtual_in, 128'h0);
		@(posedge clock);
		run <= 1'h0;
		corrupt <= 1'h0;
		rd(4'h8, 32'h3);
	endtask : t_error
	task automatic t_ctrl();
		wait_exch();
		@(posedge clock);
		run <= 1'h0;
		ctrl_reset_n <= 1'h0;
		pause(6);
		check(128'(exchange_active), 128'h0);
		check(virtual_in, 128'h0);
		@(posedge clock) ctrl_reset_n <= 1'h1;
		wait_exch();
	endtask : t_ctrl
	task automatic summarize();
		if (bad_count == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : summarize
	initial begin
		repeat (10) @(posedge clock);
		reset_n <= 1'h1;
		t_boot();
		t_extend();
		t_timeout();
		t_error();
		t_ctrl();
		summarize();
	end
	// Two loads plus traffic fit well inside this span
	initial begin
		#1000000;
		bad_count++;
		summarize();
	end
endmodule : tb_top
